// file: hw/hours_counter_pkg.sv
// Package with register map, field layout, limits and timing for the hours counter
package hours_counter_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_SPAN = 5'h04;
  localparam logic [4:0] OFS_LEFT = 5'h08;
  localparam logic [4:0] OFS_SUM = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_CLEAR = 5'h14;
  localparam logic [4:0] OFS_ENABLE = 5'h18;
  localparam logic [4:0] OFS_STATE = 5'h1C;

  // Control register field positions
  localparam int CTRL_IDLE_CLEAR_BIT = 0;
  localparam int CTRL_LIVE_SPAN_BIT = 1;

  // Widths and limits
  localparam int SPAN_W = 14;
  localparam int SUM_W = 17;
  localparam int EVT_W = 4;
  localparam logic [SPAN_W-1:0] SPAN_MAX = 14'h270F;
  localparam logic [SUM_W-1:0] SUM_MAX = 17'h1869F;

  // Reset values
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [SPAN_W-1:0] SPAN_RESET = 14'h0000;
  localparam logic [SUM_W-1:0] SUM_RESET = 17'h00000;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  // Time base
  localparam longint HOUR_S = 3600;
  localparam longint CLK_HZ = 100000000;
  localparam longint HOUR_CYCLES_DEF = HOUR_S * CLK_HZ;

  // Pin bundle
  typedef struct packed {
    logic run;
    logic intervalReset;
    logic fullClear;
  } pins_t;

  // Sticky event layout, bit 3 first from the top
  typedef struct packed {
    logic fullClear;
    logic intervalReset;
    logic saturated;
    logic alarmRise;
  } evt_t;

endpackage

// file: hw/maintenance_hours_counter.sv
// Operating hours and service interval counter with Avalon-MM registers
// Functional notes
// (RULE1) Interval reset rising edge clears alarm, reloads hours left from span.
// (RULE2) Full clear rising edge clears alarm, zeroes total, reloads hours left.
// (RULE3) Service span held in whole hours, range 0 to 9999.
// (RULE4) Run hours total stops at 99999 and never wraps.
// (RULE5) Run hours total may be preset to a starting offset.
// (RULE6) Run high: count time, hours left decreases; run low: both hold.
// (RULE7) Alarm is 1 whenever hours left equals zero.
// (RULE8) Reset-only mode: alarm low while interval reset or full clear is 1.
// (RULE9) Reset-or-idle mode: alarm also low whenever run is 0.
// (RULE10) Interval reset leaves run hours total unchanged.
// (RULE11) Total keeps counting while run is 1, whatever interval reset does.
// (RULE12) Span, hours left and total survive loss of power.
// (RULE13) Span taken either from stored value or from live external value.
// (RULE14) Span stays writable at any time, including while configuring.
// (RULE15) Hour tick from clock prescaler; counts advance only on tick with run high.
// (RULE16) Coincident interval reset and full clear edges act as full clear.
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module maintenance_hours_counter
  import hours_counter_pkg::*;
#(
  parameter longint HOUR_CYCLES = HOUR_CYCLES_DEF
) (
  // Clock, resets, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic coldRst_n,
  input wire logic clkEn,
  // Function block pins
  input wire logic runPin,
  input wire logic intervalResetPin,
  input wire logic fullClearPin,
  input wire logic [SPAN_W-1:0] liveSpan,
  output logic alarm_q,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt
  output logic irq_q
);

  localparam int PRE_W = (HOUR_CYCLES > 1) ? $clog2(HOUR_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(HOUR_CYCLES - 1);

  // Elaboration check on the time base
  if (HOUR_CYCLES < 1) begin : g_bad_hour
    $error("HOUR_CYCLES must be at least one");
  end

  // Register fields must leave room in the 32-bit data word
  if (SPAN_W >= 32 || SUM_W >= 32 || EVT_W >= 32) begin : g_bad_width
    $error("register fields must be narrower than the data word");
  end

  pins_t pinSync1_q, pinSync2_q, pinPrev_q;
  logic [1:0] ctrl_q;
  logic [SPAN_W-1:0] span_q, hoursLeft_q, spanEff;
  logic [SUM_W-1:0] runSum_q;
  logic [PRE_W-1:0] preCnt_q;
  logic [31:0] readdata_q;
  logic waitrequest_q;
  evt_t status_q, enable_q, evtNow;
  logic intervalEdge, fullClearEdge, runLvl, hourTick, alarm_d;
  logic busWr, busRd, sumWr, spanWr;

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;

  // Two-stage synchronisers for the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinSync1_q <= '0;
      pinSync2_q <= '0;
      pinPrev_q <= '0;
    end else if (clkEn) begin
      pinSync1_q <= '{run: runPin, intervalReset: intervalResetPin, fullClear: fullClearPin};
      pinSync2_q <= pinSync1_q;
      pinPrev_q <= pinSync2_q;
    end
  end

  // Edge and level decode
  assign intervalEdge = pinSync2_q.intervalReset & ~pinPrev_q.intervalReset;
  assign fullClearEdge = pinSync2_q.fullClear & ~pinPrev_q.fullClear;
  assign runLvl = pinSync2_q.run;

  // Bus strobes, taken only in the cycle waitrequest is low
  assign busWr = write & ~waitrequest_q;
  assign busRd = read & ~waitrequest_q;
  assign sumWr = busWr && (address == OFS_SUM);
  assign spanWr = busWr && (address == OFS_SPAN);

  // Effective span, live value clamped into range
  always_comb begin
    if (ctrl_q[CTRL_LIVE_SPAN_BIT]) begin // [RULE13]
      spanEff = (liveSpan > SPAN_MAX) ? SPAN_MAX : liveSpan; // [RULE3]
    end else begin
      spanEff = span_q;
    end
  end

  // Hour prescaler, runs only on run time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preCnt_q <= '0;
    end else if (clkEn && runLvl) begin // [RULE15]
      preCnt_q <= (preCnt_q == PRE_LAST) ? '0 : preCnt_q + 1'b1;
    end
  end
  assign hourTick = runLvl && (preCnt_q == PRE_LAST); // [RULE15]

  // Control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (clkEn && busWr && address == OFS_CTRL) begin
      ctrl_q <= writedata[1:0];
    end
  end

  // Stored span, retentive, writable at any time
  always_ff @(posedge clk) begin
    if (!coldRst_n) begin
      span_q <= SPAN_RESET;
    end else if (clkEn && spanWr) begin // [RULE14] [RULE12]
      span_q <= (writedata[31:SPAN_W] != '0 || writedata[SPAN_W-1:0] > SPAN_MAX) ?
                SPAN_MAX : writedata[SPAN_W-1:0]; // [RULE3]
    end
  end

  // Hours left, retentive
  always_ff @(posedge clk) begin
    if (!coldRst_n) begin
      hoursLeft_q <= SPAN_RESET;
    end else if (clkEn) begin
      if (fullClearEdge || intervalEdge) begin // [RULE1] [RULE2] [RULE16]
        hoursLeft_q <= spanEff;
      end else if (hourTick && hoursLeft_q != '0) begin // [RULE6]
        hoursLeft_q <= hoursLeft_q - 1'b1;
      end
    end
  end

  // Run hours total, retentive; interval reset does not touch it
  always_ff @(posedge clk) begin
    if (!coldRst_n) begin
      runSum_q <= SUM_RESET;
    end else if (clkEn) begin
      if (fullClearEdge) begin // [RULE2] [RULE16]
        runSum_q <= SUM_RESET;
      end else if (sumWr) begin // [RULE5]
        runSum_q <= (writedata[31:SUM_W] != '0 || writedata[SUM_W-1:0] > SUM_MAX) ?
                    SUM_MAX : writedata[SUM_W-1:0];
      end else if (hourTick && runSum_q != SUM_MAX) begin // [RULE4] [RULE11] [RULE10]
        runSum_q <= runSum_q + 1'b1;
      end
    end
  end

  // Alarm next value, clearing terms win
  always_comb begin
    alarm_d = (hoursLeft_q == '0); // [RULE7]
    if (pinSync2_q.intervalReset || pinSync2_q.fullClear || intervalEdge || fullClearEdge) begin
      alarm_d = 1'b0; // [RULE8] [RULE1] [RULE2]
    end
    if (ctrl_q[CTRL_IDLE_CLEAR_BIT] && !runLvl) begin
      alarm_d = 1'b0; // [RULE9]
    end
  end

  // Alarm output flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarm_q <= 1'b0;
    end else if (clkEn) begin
      alarm_q <= alarm_d;
    end
  end

  // Events for the sticky status
  always_comb begin
    evtNow.alarmRise = alarm_d & ~alarm_q;
    evtNow.saturated = hourTick && !fullClearEdge && !sumWr && (runSum_q == SUM_MAX - 1'b1);
    evtNow.intervalReset = intervalEdge;
    evtNow.fullClear = fullClearEdge;
  end

  // Sticky status, a new event wins over a clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= EVT_RESET;
    end else if (clkEn) begin
      if (busWr && address == OFS_CLEAR) begin
        status_q <= (status_q & ~writedata[EVT_W-1:0]) | evtNow;
      end else begin
        status_q <= status_q | evtNow;
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_q <= EVT_RESET;
    end else if (clkEn && busWr && address == OFS_ENABLE) begin
      enable_q <= writedata[EVT_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (clkEn) begin
      irq_q <= |(status_q & enable_q);
    end
  end

  // Bus handshake, one wait cycle then answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest_q <= 1'b1;
    end else if (clkEn) begin
      waitrequest_q <= !((read || write) && waitrequest_q);
    end
  end

  // Read data, latched when the request is first seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata_q <= '0;
    end else if (clkEn && read && waitrequest_q) begin
      unique case (address)
        OFS_CTRL: readdata_q <= {30'h0, ctrl_q};
        OFS_SPAN: readdata_q <= {18'h0, span_q};
        OFS_LEFT: readdata_q <= {18'h0, hoursLeft_q};
        OFS_SUM: readdata_q <= {15'h0, runSum_q};
        OFS_STATUS: readdata_q <= {28'h0, status_q};
        OFS_ENABLE: readdata_q <= {28'h0, enable_q};
        OFS_STATE: readdata_q <= {28'h0, runLvl, pinSync2_q.intervalReset,
                                  pinSync2_q.fullClear, alarm_q};
        default: readdata_q <= '0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !coldRst_n);

  // Clear pin edges, full clear taking precedence
  sequence fullClearSeq;
    clkEn && fullClearEdge;
  endsequence

  sequence intervalOnlySeq;
    clkEn && intervalEdge && !fullClearEdge;
  endsequence

  // In-range register writes
  sequence spanWriteSeq;
    clkEn && spanWr && writedata <= 32'(SPAN_MAX);
  endsequence

  sequence sumWriteSeq;
    clkEn && sumWr && !fullClearEdge && writedata <= 32'(SUM_MAX);
  endsequence

  // Alarm behaviour
  a_alarm_at_zero: assert property ( // [RULE7]
      clkEn && hoursLeft_q == '0 && !pinSync2_q.intervalReset && !pinSync2_q.fullClear &&
      !intervalEdge && !fullClearEdge && !(ctrl_q[CTRL_IDLE_CLEAR_BIT] && !runLvl) |=>
      alarm_q)
    else $error("alarm not raised at zero hours left");

  a_idle_clear: assert property ( // [RULE9]
      clkEn && ctrl_q[CTRL_IDLE_CLEAR_BIT] && !runLvl |=> !alarm_q)
    else $error("alarm high while idle in idle-clear mode");

  a_hold_clear: assert property ( // [RULE8]
      clkEn && (pinSync2_q.intervalReset || pinSync2_q.fullClear) |=> !alarm_q)
    else $error("alarm high while a clear input is 1");

  // Reload and clear actions
  a_interval_reload: assert property ( // [RULE1] [RULE10]
      intervalOnlySeq |=> hoursLeft_q == $past(spanEff) && !alarm_q &&
      (runSum_q == $past(runSum_q) || $past(hourTick) || $past(sumWr)))
    else $error("interval reset wrong");

  a_full_clear: assert property ( // [RULE2] [RULE16]
      fullClearSeq |=> runSum_q == '0 && hoursLeft_q == $past(spanEff) && !alarm_q)
    else $error("full clear wrong");

  // Span and total limits
  a_span_range: assert property ( // [RULE3]
      spanEff <= SPAN_MAX && span_q <= SPAN_MAX)
    else $error("span out of range");

  a_span_write: assert property ( // [RULE14]
      spanWriteSeq |=> {18'h0, span_q} == $past(writedata))
    else $error("span write not stored");

  a_sum_preset: assert property ( // [RULE5]
      sumWriteSeq |=> {15'h0, runSum_q} == $past(writedata))
    else $error("total preset not stored");

  a_sum_saturate: assert property ( // [RULE4]
      clkEn && runSum_q == SUM_MAX && !fullClearEdge && !sumWr |=> runSum_q == SUM_MAX)
    else $error("total wrapped past limit");

  // Counting on the hour tick
  a_hold_idle: assert property ( // [RULE6]
      clkEn && !runLvl && !intervalEdge && !fullClearEdge && !sumWr |=>
      $stable(runSum_q) && $stable(hoursLeft_q))
    else $error("count moved while idle");

  a_tick_count: assert property ( // [RULE15] [RULE11]
      clkEn && hourTick && !intervalEdge && !fullClearEdge && !sumWr &&
      hoursLeft_q != '0 && runSum_q != SUM_MAX |=>
      hoursLeft_q == $past(hoursLeft_q) - 1'b1 && runSum_q == $past(runSum_q) + 1'b1)
    else $error("tick did not advance counts");

  a_enable_freeze: assert property (!clkEn |=> $stable(hoursLeft_q) && $stable(runSum_q) &&
      $stable(alarm_q) && $stable(status_q) && $stable(waitrequest_q))
    else $error("state moved while clock enable low");

  // Status, interrupt and bus handshake
  a_status_sticky: assert property (clkEn && !(busWr && address == OFS_CLEAR) |=>
      (status_q & $past(status_q)) == $past(status_q))
    else $error("status bit lost without a clear");

  a_irq_follow: assert property (clkEn && (status_q & enable_q) != '0 |=> irq_q)
    else $error("interrupt low with an enabled status bit");

  a_irq_quiet: assert property (clkEn && (status_q & enable_q) == '0 |=> !irq_q)
    else $error("interrupt high with no enabled status bit");

  a_bus_answer: assert property (clkEn && (read || write) && waitrequest_q |=> !waitrequest_q)
    else $error("bus not answered after one cycle");

  a_wait_release: assert property (clkEn && !waitrequest_q |=> waitrequest_q)
    else $error("waitrequest low for more than one cycle");

endmodule // maintenance_hours_counter

// file: dv/maintenance_hours_counter_tb_top.sv
// Directed testbench for the maintenance hours counter over Avalon-MM
`timescale 1ns/10ps
module maintenance_hours_counter_tb_top;
  import hours_counter_pkg::*;
  // Stimulus and observation signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic coldRst_n = 1'b0;
  logic clkEn = 1'b1;
  logic runPin = 1'b0;
  logic intervalResetPin = 1'b0;
  logic fullClearPin = 1'b0;
  logic [SPAN_W-1:0] liveSpan = 14'h0000;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic [31:0] v;
  logic alarm_q;
  logic waitrequest;
  logic irq_q;
  int fails = 0;
  int checked = 0;

  // Short hour so each tick is eight run cycles
  maintenance_hours_counter #(.HOUR_CYCLES(8)) dut (
    .clk(clk), .rst_n(rst_n), .coldRst_n(coldRst_n), .clkEn(clkEn),
    .runPin(runPin), .intervalResetPin(intervalResetPin), .fullClearPin(fullClearPin),
    .liveSpan(liveSpan), .alarm_q(alarm_q), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq_q(irq_q));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Avalon write, held until waitrequest low
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  // Avalon read, data taken at the completing edge
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    v = readdata;
    read <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, v);
  endtask

  // Pin levels, then time to pass the synchroniser
  task automatic pins(input logic r, input logic i, input logic f);
    @(posedge clk);
    runPin <= r;
    intervalResetPin <= i;
    fullClearPin <= f;
    repeat (6) @(posedge clk);
  endtask

  // Bounded wait for an alarm level
  task automatic waitAlarm(input logic lvl);
    repeat (400) begin
      if (alarm_q === lvl) break;
      @(posedge clk);
    end
    chk("alarm", {31'h0, lvl}, {31'h0, alarm_q});
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against hangs
  initial begin
    #500000;
    fails++;
    results();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    chk("alarm in reset", 32'h0, {31'h0, alarm_q});
    rst_n <= 1'b1;
    coldRst_n <= 1'b1;
    rchk("ctrl", OFS_CTRL, 32'h0);
    rchk("span", OFS_SPAN, 32'h0);
    rchk("sum", OFS_SUM, 32'h0);
    rchk("enable", OFS_ENABLE, 32'h0);
    done("reset");
    wr(OFS_SPAN, 32'h0000FFFF);
    rchk("span clamp", OFS_SPAN, 32'h270F);
    wr(OFS_SPAN, 32'h3);
    rchk("span", OFS_SPAN, 32'h3);
    wr(OFS_LEFT, 32'h5);
    rchk("left ro", OFS_LEFT, 32'h0);
    done("registers");
    pins(1'b0, 1'b1, 1'b0);
    chk("alarm int", 32'h0, {31'h0, alarm_q});
    rchk("left int", OFS_LEFT, 32'h3);
    pins(1'b0, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0);
    waitAlarm(1'b1);
    pins(1'b0, 1'b0, 1'b0);
    rchk("left run", OFS_LEFT, 32'h0);
    rchk("sum run", OFS_SUM, 32'h3);
    repeat (40) @(posedge clk);
    rchk("sum hold", OFS_SUM, 32'h3);
    done("count");
    pins(1'b0, 1'b1, 1'b0);
    chk("alarm int2", 32'h0, {31'h0, alarm_q});
    rchk("sum kept", OFS_SUM, 32'h3);
    pins(1'b1, 1'b1, 1'b0);
    repeat (60) @(posedge clk);
    chk("alarm int level", 32'h0, {31'h0, alarm_q});
    pins(1'b0, 1'b1, 1'b0);
    rd(OFS_SUM);
    chk("sum grew", 32'h1, {31'h0, v > 32'h3});
    pins(1'b0, 1'b0, 1'b0);
    waitAlarm(1'b1);
    done("interval");
    wr(OFS_CTRL, 32'h1);
    waitAlarm(1'b0);
    pins(1'b1, 1'b0, 1'b0);
    waitAlarm(1'b1);
    pins(1'b0, 1'b0, 1'b0);
    waitAlarm(1'b0);
    wr(OFS_CTRL, 32'h0);
    waitAlarm(1'b1);
    done("idle mode");
    pins(1'b0, 1'b0, 1'b1);
    chk("alarm full", 32'h0, {31'h0, alarm_q});
    rchk("sum full", OFS_SUM, 32'h0);
    rchk("left full", OFS_LEFT, 32'h3);
    rchk("state full", OFS_STATE, 32'h2);
    rchk("status events", OFS_STATUS, 32'hD);
    pins(1'b0, 1'b0, 1'b0);
    done("full clear");
    wr(OFS_SUM, 32'h1869E);
    rchk("sum preset", OFS_SUM, 32'h1869E);
    wr(OFS_ENABLE, 32'h2);
    pins(1'b1, 1'b0, 1'b0);
    repeat (40) @(posedge clk);
    pins(1'b0, 1'b0, 1'b0);
    rchk("sum sat", OFS_SUM, 32'h1869F);
    rd(OFS_STATUS);
    chk("status sat", 32'h2, v & 32'h2);
    chk("irq on", 32'h1, {31'h0, irq_q});
    wr(OFS_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq_q});
    wr(OFS_ENABLE, 32'h2);
    wr(OFS_CLEAR, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq_q});
    rd(OFS_STATUS);
    chk("status clr", 32'h0, v & 32'h2);
    wr(OFS_SUM, 32'h1FFFF);
    rchk("sum clamp", OFS_SUM, 32'h1869F);
    done("saturation");
    @(posedge clk) liveSpan <= 14'h0005;
    wr(OFS_CTRL, 32'h2);
    pins(1'b0, 1'b1, 1'b0);
    rchk("left live", OFS_LEFT, 32'h5);
    pins(1'b0, 1'b0, 1'b0);
    @(posedge clk) liveSpan <= 14'h3FFF;
    pins(1'b0, 1'b1, 1'b0);
    rchk("left live clamp", OFS_LEFT, 32'h270F);
    pins(1'b0, 1'b0, 1'b0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_SUM, 32'h7);
    pins(1'b0, 1'b1, 1'b1);
    rchk("sum both", OFS_SUM, 32'h0);
    rchk("left both", OFS_LEFT, 32'h3);
    pins(1'b0, 1'b0, 1'b0);
    done("live span");
    wr(OFS_SUM, 32'h9);
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk("span kept", OFS_SPAN, 32'h3);
    rchk("sum kept", OFS_SUM, 32'h9);
    rchk("left kept", OFS_LEFT, 32'h3);
    done("retention");
    // Run seen for a few cycles, then frozen for ten hours' worth of cycles
    @(posedge clk) runPin <= 1'b1;
    repeat (3) @(posedge clk);
    clkEn <= 1'b0;
    repeat (80) @(posedge clk);
    clkEn <= 1'b1;
    runPin <= 1'b0;
    rchk("sum frozen", OFS_SUM, 32'h9);
    rchk("left frozen", OFS_LEFT, 32'h3);
    done("enable");
    results();
  end
endmodule // maintenance_hours_counter_tb_top
